// [rtl/atl_pkg.sv]
// Purpose: shared constants and types of the addressable tap linker
// Assumes: 10-bit board address, bit-pair symbols of two test clock samples
// Notes: global codes and symbol values are defaults only; the top can override them through its parameters
package atl_pkg;

  // address and acknowledgement sizes
  localparam int ADDR_W = 10;
  localparam int ACK_HALVES = 2 * ADDR_W;
  localparam logic [3:0] ADDR_LAST = 4'h9;
  localparam logic [4:0] ACK_LAST = 5'h14;

  // default global codes, arbitrary values
  localparam logic [ADDR_W-1:0] DISC_CODE_DEF = 10'h000;
  localparam logic [ADDR_W-1:0] RST_CODE_DEF = 10'h001;
  localparam logic [ADDR_W-1:0] SYNC_CODE_DEF = 10'h002;

  // default bit-pair symbols, first sample in the high bit
  localparam logic [1:0] PAIR_ZERO_DEF = 2'h1;
  localparam logic [1:0] PAIR_ONE_DEF = 2'h2;
  localparam logic [1:0] PAIR_START_DEF = 2'h0;
  localparam logic [1:0] PAIR_END_DEF = 2'h3;

  // values after reset
  localparam logic [1:0] WIN_RST = 2'h3;
  localparam logic SYNC_RST_HI = 1'b1;
  localparam logic SYNC_RST_LO = 1'b0;

  // test access port controller states
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR,
    TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
    TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } atl_tap_t;

  // link status of the switch
  typedef enum logic [1:0] {LS_RESET, LS_OFF, LS_ON, LS_MULTI} atl_link_t;

  // addressing receiver states
  typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_END, RX_ACK} atl_rx_t;

endpackage

// [rtl/atl_link_if.sv]
// Purpose: carrier between the linker core, the tap tracker and the ack sender
// Assumes: all signals on ref_clk_in
// Notes: edge strobes are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface atl_link_if;
  logic tck_rise;
  logic tck_fall;
  logic tms_s;
  logic trst_s_n;
  logic proto_ok;
  logic pause_ok;
  logic ack_start;
  logic [atl_pkg::ADDR_W-1:0] ack_addr;
  logic ack_busy;
  logic ack_done;
  logic ack_bit;
  modport tap (input tck_rise, tms_s, trst_s_n, output proto_ok, pause_ok);
  modport ack (input tck_fall, ack_start, ack_addr, output ack_busy, ack_done, ack_bit);
  modport core (output tck_rise, tck_fall, tms_s, trst_s_n, ack_start, ack_addr,
                input proto_ok, pause_ok, ack_busy, ack_done, ack_bit);
endinterface
`default_nettype wire

// [rtl/atl_tap_tracker.sv]
// Purpose: follows the primary tap controller state from mode select
// Assumes: edge strobe and mode select already synchronised
// Notes: test reset low forces Test-Logic-Reset
`timescale 1ns/1ps
`default_nettype none
module atl_tap_tracker (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  atl_link_if.tap lnk
);
  import atl_pkg::*;

  atl_tap_t tap_r;
  atl_tap_t tap_nxt;

  // standard controller transitions
  always_comb begin
    tap_nxt = tap_r;
    case (tap_r)
      TAP_RESET: tap_nxt = lnk.tms_s ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: tap_nxt = lnk.tms_s ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_nxt = lnk.tms_s ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_nxt = lnk.tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: tap_nxt = lnk.tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: tap_nxt = lnk.tms_s ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: tap_nxt = lnk.tms_s ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: tap_nxt = lnk.tms_s ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: tap_nxt = lnk.tms_s ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_nxt = lnk.tms_s ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: tap_nxt = lnk.tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: tap_nxt = lnk.tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: tap_nxt = lnk.tms_s ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: tap_nxt = lnk.tms_s ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: tap_nxt = lnk.tms_s ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: tap_nxt = lnk.tms_s ? TAP_SEL_DR : TAP_IDLE;
      default: tap_nxt = TAP_RESET;
    endcase
  end

  // state advances on each test clock rising edge
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || !lnk.trst_s_n) begin
      tap_r <= TAP_RESET;
    end else if (lnk.tck_rise) begin
      tap_r <= tap_nxt;
    end
  end

  // addressing allowed only in the four stable non-shift states
  assign lnk.proto_ok = (tap_r == TAP_RESET) || (tap_r == TAP_IDLE) ||
                        (tap_r == TAP_PAUSE_DR) || (tap_r == TAP_PAUSE_IR);
  assign lnk.pause_ok = (tap_r == TAP_PAUSE_DR) || (tap_r == TAP_PAUSE_IR);
endmodule
`default_nettype wire

// [rtl/atl_ack_sender.sv]
// Purpose: sends the board address back as bit pairs on primary data out
// Assumes: falling edge strobe from the synchronised test clock
// Notes: most significant bit first, one half-bit per falling edge
`timescale 1ns/1ps
`default_nettype none
module atl_ack_sender #(
  parameter logic [1:0] PAIR_ZERO = atl_pkg::PAIR_ZERO_DEF,
  parameter logic [1:0] PAIR_ONE = atl_pkg::PAIR_ONE_DEF
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  atl_link_if.ack lnk
);
  import atl_pkg::*;

  logic [ACK_HALVES-1:0] pat;
  logic [ACK_HALVES-1:0] sh_r;
  logic [4:0] cnt_r;
  logic busy_r;
  logic done_r;
  logic bit_r;

  // expand each address bit into its symbol
  genvar gi;
  generate
    for (gi = 0; gi < ADDR_W; gi++) begin : g_sym
      assign pat[2*gi+1:2*gi] = lnk.ack_addr[gi] ? PAIR_ONE : PAIR_ZERO;
    end
  endgenerate

  // shifter changes data on test clock falling edges
  always_ff @(posedge ref_clk_in) begin
    done_r <= 1'b0;
    if (rst_in) begin
      busy_r <= 1'b0;
      cnt_r <= '0;
      sh_r <= '0;
      bit_r <= 1'b1;
    end else if (lnk.ack_start && !busy_r) begin
      busy_r <= 1'b1;
      cnt_r <= '0;
      sh_r <= pat;
      bit_r <= 1'b1;
    end else if (busy_r && lnk.tck_fall) begin
      if (cnt_r == ACK_LAST) begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
      end else begin
        bit_r <= sh_r[ACK_HALVES-1];
        sh_r <= {sh_r[ACK_HALVES-2:0], 1'b0};
        cnt_r <= cnt_r + 5'h1;
      end
    end
  end

  assign lnk.ack_busy = busy_r;
  assign lnk.ack_done = done_r;
  assign lnk.ack_bit = bit_r;
endmodule
`default_nettype wire

// [rtl/atl_tap_linker.sv]
// Purpose: addressable switch between a multidrop primary test port and a board test port
// Assumes: ref_clk_in much faster than the primary test clock, which it samples
// Notes: forward paths and force-link act combinationally on the raw pins
//
// Operation
// - after power-up, without force-link, start in reset with ports disconnected.
// - primary clock and reset always pass straight to the secondary port.
// - reset condition on power-up, test reset, or global reset code.
// - linked paths are pure wires, no storage or retiming.
// - unlinked: secondary data out floats; primary data out floats except acknowledging.
// - on link drop secondary mode select keeps its last level.
// - in reset without force-link, or with test reset low, secondary mode select is high.
// - track tap state; addressing only in the four stable non-shift states.
// - receive a 10-bit bit-pair address and compare with board address.
// - on match send own address back, then link.
// - on mismatch unlink at once without acknowledgement.
// - global disconnect code unlinks like a mismatch.
// - global reset code enters the reset condition.
// - global sync code: forward paths and indicator low, primary data out floats.
// - global sync code honoured only in the pause states.
// - force-link low links asynchronously, regardless of any reset.
// - addressing ignored while force-link is low.
// - link indicator low whenever linked, high when unlinked.
// - force-link and test reset low: forward data, indicator low, mode select high.
// - releasing test reset with force-link low returns to forced link at once.
// - intolerable sequence variations are hard errors and unlink.
// - primary data in is sampled on test clock rising edges.
// - acknowledgement bits change on test clock falling edges.
// - board address compared most significant bit first.
// - test reset low returns tap, receiver and link state to power-up condition; the ack shifter keeps running.
`timescale 1ns/1ps
`default_nettype none
module atl_tap_linker #(
  parameter logic [atl_pkg::ADDR_W-1:0] DISC_CODE = atl_pkg::DISC_CODE_DEF,
  parameter logic [atl_pkg::ADDR_W-1:0] RST_CODE = atl_pkg::RST_CODE_DEF,
  parameter logic [atl_pkg::ADDR_W-1:0] SYNC_CODE = atl_pkg::SYNC_CODE_DEF,
  parameter logic [1:0] PAIR_ZERO = atl_pkg::PAIR_ZERO_DEF,
  parameter logic [1:0] PAIR_ONE = atl_pkg::PAIR_ONE_DEF,
  parameter logic [1:0] PAIR_START = atl_pkg::PAIR_START_DEF,
  parameter logic [1:0] PAIR_END = atl_pkg::PAIR_END_DEF
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic primary_test_clock_in,
  input wire logic primary_test_reset_n_in,
  input wire logic primary_mode_select_in,
  input wire logic primary_data_in,
  output logic primary_data_out,
  output logic primary_data_oe_out,
  input wire logic secondary_data_in,
  output logic secondary_test_clock_out,
  output logic secondary_test_reset_n_out,
  output logic secondary_mode_select_out,
  output logic secondary_data_out,
  output logic secondary_data_oe_out,
  input wire logic [atl_pkg::ADDR_W-1:0] board_address_inputs_in,
  input wire logic force_link_n_in,
  output logic link_active_n_out,
  output atl_pkg::atl_link_t link_status_out
);
  import atl_pkg::*;

  atl_link_if lnk ();

  // pin synchronisers, first stage read only by the second
  logic tck_s1_r;
  logic tck_s2_r;
  logic tck_prev_r;
  logic tdi_s1_r;
  logic tdi_s2_r;
  logic tms_s1_r;
  logic tms_s2_r;
  logic trst_s1_r;
  logic trst_s2_r;
  logic frc_s1_r;
  logic frc_s2_r;
  logic [ADDR_W-1:0] addr_s1_r;
  logic [ADDR_W-1:0] addr_s2_r;

  // receiver and status state
  atl_rx_t rx_r;
  atl_link_t ls_r;
  logic [1:0] win_r;
  logic half_r;
  logic first_r;
  logic [3:0] cnt_r;
  logic [ADDR_W-1:0] rx_addr_r;
  logic done_r;
  logic err_r;
  logic tms_hold_r;

  // combinational decode terms
  logic sess_ok;
  logic [1:0] pair;
  logic pair_bit;
  logic pair_data;
  logic is_rst;
  logic is_disc;
  logic is_sync;
  logic is_match;
  logic forced;
  logic trst_pin;
  logic proto_fwd;
  logic fwd_paths;
  logic ack_on;

  // test clock chain plus one delay stage for edge finding
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      tck_s1_r <= SYNC_RST_LO;
      tck_s2_r <= SYNC_RST_LO;
      tck_prev_r <= SYNC_RST_LO;
    end else begin
      tck_s1_r <= primary_test_clock_in;
      tck_s2_r <= tck_s1_r;
      tck_prev_r <= tck_s2_r;
    end
  end

  // data and mode select chains, same depth as the clock so samples line up
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      tdi_s1_r <= SYNC_RST_HI;
      tdi_s2_r <= SYNC_RST_HI;
      tms_s1_r <= SYNC_RST_HI;
      tms_s2_r <= SYNC_RST_HI;
    end else begin
      tdi_s1_r <= primary_data_in;
      tdi_s2_r <= tdi_s1_r;
      tms_s1_r <= primary_mode_select_in;
      tms_s2_r <= tms_s1_r;
    end
  end

  // test reset and force-link chains, idle high like their pins
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      trst_s1_r <= SYNC_RST_HI;
      trst_s2_r <= SYNC_RST_HI;
      frc_s1_r <= SYNC_RST_HI;
      frc_s2_r <= SYNC_RST_HI;
    end else begin
      trst_s1_r <= primary_test_reset_n_in;
      trst_s2_r <= trst_s1_r;
      frc_s1_r <= force_link_n_in;
      frc_s2_r <= frc_s1_r;
    end
  end

  // board address straps, msb in the top bit
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      addr_s1_r <= '1;
      addr_s2_r <= '1;
    end else begin
      addr_s1_r <= board_address_inputs_in;
      addr_s2_r <= addr_s1_r;
    end
  end

  // edge strobes and shared signals
  assign lnk.tck_rise = tck_s2_r && !tck_prev_r;
  assign lnk.tck_fall = !tck_s2_r && tck_prev_r;
  assign lnk.tms_s = tms_s2_r;
  assign lnk.trst_s_n = trst_s2_r;
  assign lnk.ack_addr = addr_s2_r;

  // tap state follower
  atl_tap_tracker u_tap (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .lnk(lnk)
  );

  // acknowledgement shifter
  atl_ack_sender #(
    .PAIR_ZERO(PAIR_ZERO),
    .PAIR_ONE(PAIR_ONE)
  ) u_ack (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .lnk(lnk)
  );

  // addressing accepted only in stable states, unforced, out of test reset
  assign sess_ok = lnk.proto_ok && frc_s2_r && trst_s2_r;

  // current symbol and its decoded bit
  assign pair = {first_r, tdi_s2_r};
  assign pair_data = (pair == PAIR_ZERO) || (pair == PAIR_ONE);
  assign pair_bit = (pair == PAIR_ONE);

  // classify the received address, global codes first
  assign is_rst = (rx_addr_r == RST_CODE);
  assign is_disc = (rx_addr_r == DISC_CODE);
  assign is_sync = (rx_addr_r == SYNC_CODE);
  assign is_match = (rx_addr_r == addr_s2_r) && !is_rst && !is_disc && !is_sync;

  // bit-pair receiver sampled on rising test clock edges
  always_ff @(posedge ref_clk_in) begin
    done_r <= 1'b0;
    err_r <= 1'b0;
    if (rst_in || !trst_s2_r) begin
      rx_r <= RX_IDLE;
      win_r <= WIN_RST;
      half_r <= 1'b0;
      first_r <= 1'b1;
      cnt_r <= '0;
      rx_addr_r <= '0;
    end else if (rx_r == RX_ACK) begin
      if (lnk.ack_done) begin
        rx_r <= RX_IDLE;
        win_r <= WIN_RST;
      end
    end else if (!sess_ok) begin
      rx_r <= RX_IDLE;
      win_r <= WIN_RST;
      half_r <= 1'b0;
    end else if (lnk.tck_rise) begin
      case (rx_r)
        RX_IDLE: begin
          win_r <= {win_r[0], tdi_s2_r};
          if ({win_r[0], tdi_s2_r} == PAIR_START) begin
            rx_r <= RX_DATA;
            half_r <= 1'b0;
            cnt_r <= '0;
          end
        end
        RX_DATA: begin
          half_r <= !half_r;
          if (!half_r) begin
            first_r <= tdi_s2_r;
          end else if (pair_data) begin
            rx_addr_r <= {rx_addr_r[ADDR_W-2:0], pair_bit};
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == ADDR_LAST) begin
              rx_r <= RX_END;
            end
          end else begin
            rx_r <= RX_IDLE;
            win_r <= WIN_RST;
            err_r <= 1'b1;
          end
        end
        RX_END: begin
          half_r <= !half_r;
          if (!half_r) begin
            first_r <= tdi_s2_r;
          end else if (pair == PAIR_END) begin
            done_r <= 1'b1;
            rx_r <= is_match ? RX_ACK : RX_IDLE;
            win_r <= WIN_RST;
          end else begin
            rx_r <= RX_IDLE;
            win_r <= WIN_RST;
            err_r <= 1'b1;
          end
        end
        default: rx_r <= RX_IDLE;
      endcase
    end
  end

  // acknowledgement begins as soon as a matching address completes
  assign lnk.ack_start = done_r && is_match;

  // an acknowledgement counts only while the receiver waits for it; a test
  // reset mid-ack leaves the shifter running but silences it and its link-up
  assign ack_on = lnk.ack_busy && (rx_r == RX_ACK) && !trst_pin;

  // link status decided by the addressing result
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || !trst_s2_r) begin
      ls_r <= LS_RESET;
    end else if (err_r) begin
      ls_r <= LS_OFF;
    end else if (done_r) begin
      if (is_rst) begin
        ls_r <= LS_RESET;
      end else if (is_disc) begin
        ls_r <= LS_OFF;
      end else if (is_sync) begin
        if (lnk.pause_ok) begin
          ls_r <= LS_MULTI;
        end
      end else if (!is_match) begin
        ls_r <= LS_OFF;
      end
    end else if (lnk.ack_done && (rx_r == RX_ACK)) begin
      ls_r <= LS_ON;
    end
  end

  // raw pin terms so forcing and test reset act without the clock
  assign forced = !force_link_n_in;
  assign trst_pin = !primary_test_reset_n_in;
  assign proto_fwd = !trst_pin && ((ls_r == LS_ON) || (ls_r == LS_MULTI));
  assign fwd_paths = forced || proto_fwd;

  // remember the last forwarded mode select level
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || !trst_s2_r || (ls_r == LS_RESET)) begin
      tms_hold_r <= 1'b1;
    end else if (fwd_paths) begin
      tms_hold_r <= tms_s2_r;
    end
  end

  // clock and reset always pass through
  assign secondary_test_clock_out = primary_test_clock_in;
  assign secondary_test_reset_n_out = primary_test_reset_n_in;

  // secondary mode select: high in test reset, forwarded when linked, else high in reset or held
  always_comb begin
    if (trst_pin) begin
      secondary_mode_select_out = 1'b1;
    end else if (fwd_paths) begin
      secondary_mode_select_out = primary_mode_select_in;
    end else if (ls_r == LS_RESET) begin
      secondary_mode_select_out = 1'b1;
    end else begin
      secondary_mode_select_out = tms_hold_r;
    end
  end

  // data forward paths, pure wires
  assign secondary_data_out = primary_data_in;
  assign secondary_data_oe_out = fwd_paths;

  // primary data out: ack, then return data in full link, else floating
  assign primary_data_out = ack_on ? lnk.ack_bit : secondary_data_in;
  assign primary_data_oe_out = ack_on || forced || (!trst_pin && (ls_r == LS_ON));

  // link indicator and status
  assign link_active_n_out = !fwd_paths;
  assign link_status_out = ls_r;
endmodule
`default_nettype wire

// [tb/atl_board_chain.sv]
// Purpose: board-level test port model behind the secondary side
// Assumes: clocked only by the secondary test clock
// Notes: a released data line shifts in a changing pattern, never a stale value
`timescale 1ns/1ps
`default_nettype none
module atl_board_chain (
  input wire logic tck_in,
  input wire logic tdi_in,
  input wire logic tdi_oe_in,
  output logic tdo_out
);
  logic [4:0] chain_r = 5'h0b;
  // capture on the rising test clock
  always @(posedge tck_in) begin
    chain_r <= {chain_r[3:0], tdi_oe_in ? tdi_in : ~chain_r[0]};
  end
  // board data out changes on the falling test clock
  initial tdo_out = 1'b0;
  always @(negedge tck_in) begin
    tdo_out <= chain_r[4];
  end
endmodule
`default_nettype wire

// [tb/atl_tap_linker_asserts.sv]
// Purpose: port checker for the tap linker
// Assumes: all checks sampled on the system clock
// Notes: bound to every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module atl_tap_linker_asserts
  import atl_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic primary_test_clock_in,
  input wire logic primary_test_reset_n_in,
  input wire logic primary_mode_select_in,
  input wire logic primary_data_in,
  input wire logic primary_data_oe_out,
  input wire logic secondary_test_clock_out,
  input wire logic secondary_test_reset_n_out,
  input wire logic secondary_mode_select_out,
  input wire logic secondary_data_out,
  input wire logic secondary_data_oe_out,
  input wire logic force_link_n_in,
  input wire logic link_active_n_out,
  input wire atl_pkg::atl_link_t link_status_out
);
  // one clock domain for every check
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  property p_thru;
    secondary_test_clock_out == primary_test_clock_in && secondary_test_reset_n_out == primary_test_reset_n_in;
  endproperty
  a_thru: assert property (p_thru) else $error("secondary clock or reset differs");
  property p_fwd_on;
    link_status_out == LS_ON && force_link_n_in && primary_test_reset_n_in |-> secondary_data_oe_out &&
      secondary_data_out == primary_data_in && secondary_mode_select_out == primary_mode_select_in;
  endproperty
  a_fwd_on: assert property (p_fwd_on) else $error("linked paths not forwarded");
  property p_off;
    (link_status_out == LS_OFF || link_status_out == LS_RESET) && force_link_n_in |->
      !secondary_data_oe_out && link_active_n_out;
  endproperty
  a_off: assert property (p_off) else $error("unlinked port still driven");
  property p_rst_mode;
    !primary_test_reset_n_in || (link_status_out == LS_RESET && force_link_n_in) |-> secondary_mode_select_out;
  endproperty
  a_rst_mode: assert property (p_rst_mode) else $error("mode select low in reset");
  property p_hold;
    link_status_out == LS_OFF && $past(link_status_out) == LS_OFF && force_link_n_in && $past(force_link_n_in)
      && primary_test_reset_n_in && $past(primary_test_reset_n_in) |-> $stable(secondary_mode_select_out);
  endproperty
  a_hold: assert property (p_hold) else $error("held mode select moved");
  property p_multi;
    link_status_out == LS_MULTI && force_link_n_in && primary_test_reset_n_in |-> !primary_data_oe_out &&
      !link_active_n_out && secondary_data_oe_out && secondary_mode_select_out == primary_mode_select_in;
  endproperty
  a_multi: assert property (p_multi) else $error("multicast outputs wrong");
  property p_force;
    !force_link_n_in |-> !link_active_n_out && secondary_data_oe_out && secondary_data_out == primary_data_in;
  endproperty
  a_force: assert property (p_force) else $error("forced link not active");
  property p_force_trst;
    !force_link_n_in && !primary_test_reset_n_in |-> secondary_mode_select_out && primary_data_oe_out;
  endproperty
  a_force_trst: assert property (p_force_trst) else $error("forced link in reset wrong");
  property p_ack_first;
    $rose(link_status_out == LS_ON) |-> $past(primary_data_oe_out) || $past(primary_data_oe_out, 2);
  endproperty
  a_ack_first: assert property (p_ack_first) else $error("linked without acknowledgement");
  property p_trst_clr;
    $fell(primary_test_reset_n_in) |-> ##[1:5] link_status_out == LS_RESET;
  endproperty
  a_trst_clr: assert property (p_trst_clr) else $error("test reset did not clear state");
  // main scenarios reached
  c_on: cover property (link_status_out == LS_ON);
  c_multi: cover property (link_status_out == LS_MULTI);
  c_force_trst: cover property (!force_link_n_in && !primary_test_reset_n_in);
endmodule
bind atl_tap_linker atl_tap_linker_asserts u_chk (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .primary_test_clock_in(primary_test_clock_in),
  .primary_test_reset_n_in(primary_test_reset_n_in), .primary_mode_select_in(primary_mode_select_in),
  .primary_data_in(primary_data_in), .primary_data_oe_out(primary_data_oe_out),
  .secondary_test_clock_out(secondary_test_clock_out), .secondary_test_reset_n_out(secondary_test_reset_n_out),
  .secondary_mode_select_out(secondary_mode_select_out), .secondary_data_out(secondary_data_out),
  .secondary_data_oe_out(secondary_data_oe_out), .force_link_n_in(force_link_n_in),
  .link_active_n_out(link_active_n_out), .link_status_out(link_status_out)
);
`default_nettype wire

// [tb/tb_atl_tap_linker.sv]
// Purpose: self-checking bench for the tap linker
// Assumes: default global codes and bit-pair symbols
// Notes: the test clock runs only inside frames, tap moves and the linked data shift
`timescale 1ns/1ps
`default_nettype none
module tb_atl_tap_linker;
  import atl_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic tck = 1'b0;
  logic trst_n = 1'b1;
  logic tms = 1'b1;
  logic tdi = 1'b1;
  logic force_n = 1'b1;
  logic [9:0] own = 10'h000;
  logic pdo, pdo_oe, sdi, secondary_test_clock, secondary_test_reset_n_n, smode, sdo, sdo_oe, link_n, smp_oe, smp_do;
  atl_link_t status;
  int n_errors = 0;
  int total_checks = 0;
  int exp_st = 0;
  int seed = 16249;
  bit exp_fwd = 1'b0;
  atl_tap_linker dut (
    .ref_clk_in(ref_clk), .rst_in(rst), .primary_test_clock_in(tck), .primary_test_reset_n_in(trst_n),
    .primary_mode_select_in(tms), .primary_data_in(tdi), .primary_data_out(pdo), .primary_data_oe_out(pdo_oe),
    .secondary_data_in(sdi), .secondary_test_clock_out(secondary_test_clock), .secondary_test_reset_n_out(secondary_test_reset_n_n),
    .secondary_mode_select_out(smode), .secondary_data_out(sdo), .secondary_data_oe_out(sdo_oe),
    .board_address_inputs_in(own), .force_link_n_in(force_n), .link_active_n_out(link_n),
    .link_status_out(status)
  );
  atl_board_chain u_board (.tck_in(secondary_test_clock), .tdi_in(sdo), .tdi_oe_in(sdo_oe), .tdo_out(sdi));
  // system clock
  always #5 ref_clk = ~ref_clk;
  task automatic check(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one test clock period, outputs sampled just before the fall
  task automatic tck_cycle(input logic m, input logic d);
    #1 tms = m;
    tdi = d;
    #61.5 tck = 1'b1;
    #60 smp_oe = pdo_oe;
    smp_do = pdo;
    if (exp_fwd) begin
      check(sdo, tdi, "data to board");
      check(pdo, sdi, "data from board");
      check(smode, tms, "mode to board");
    end
    #1 tck = 1'b0;
    #1.5;
  endtask
  task automatic steps(input logic [7:0] s, input int n);
    for (int i = n - 1; i >= 0; i--) tck_cycle(s[i], 1'b1);
  endtask
  // status, indicator and board data enable against the model
  task automatic chk_st(input string name);
    check(status === atl_link_t'(exp_st[1:0]), 1'b1, "link status");
    check(link_n, exp_st < 2, "link indicator");
    check(sdo_oe, exp_st >= 2, "board data enable");
    if (exp_st == 0) check(smode, 1'b1, "mode select in reset");
    $display("test %s done", name);
  endtask
  // addressing frame, model update, then acknowledgement window
  task automatic frame(input logic m, input logic [9:0] a, input int bad, input int acc);
    logic [1:0] pr;
    bit ack;
    logic q[$];
    tck_cycle(m, PAIR_START_DEF[1]);
    tck_cycle(m, PAIR_START_DEF[0]);
    for (int i = 9; i >= 0; i--) begin
      pr = (i == bad) ? PAIR_END_DEF : (a[i] ? PAIR_ONE_DEF : PAIR_ZERO_DEF);
      q.push_back(own[i] ? PAIR_ONE_DEF[1] : PAIR_ZERO_DEF[1]);
      q.push_back(own[i] ? PAIR_ONE_DEF[0] : PAIR_ZERO_DEF[0]);
      tck_cycle(m, pr[1]);
      tck_cycle(m, pr[0]);
    end
    tck_cycle(m, PAIR_END_DEF[1]);
    tck_cycle(m, PAIR_END_DEF[0]);
    ack = 1'b0;
    if (acc != 0 && force_n && trst_n) begin
      if (bad >= 0 || a == DISC_CODE_DEF) exp_st = 1;
      else if (a == RST_CODE_DEF) exp_st = 0;
      else if (a == SYNC_CODE_DEF) begin
        if (acc == 2) exp_st = 3;
      end else if (a == own) begin
        exp_st = 2;
        ack = 1'b1;
      end else exp_st = 1;
    end
    for (int k = 0; k < 21; k++) begin
      tck_cycle(m, 1'b1);
      check(smp_oe, ack || exp_st == 2 || !force_n, "primary data enable");
      if (ack && k < 20) check(smp_do, q.pop_front(), "acknowledge half");
    end
  endtask
  // time limit on the whole run
  initial begin
    #400us n_errors++;
    $display("unexpected at %0t: run hung", $time);
    end_of_test();
  end
  initial begin
    own = 10'($random(seed)) | 10'h004;
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk_st("power up");
    steps(8'h00, 1);
    frame(1'b0, own, -1, 1);
    chk_st("match");
    steps(8'h04, 3);
    exp_fwd = 1'b1;
    repeat (8) tck_cycle(1'b0, 1'($random(seed)));
    exp_fwd = 1'b0;
    frame(1'b0, own ^ 10'h200, -1, 0);
    chk_st("shift ignores");
    steps(8'h06, 3);
    frame(1'b0, own, 4, 1);
    chk_st("hard error");
    @(negedge ref_clk);
    tms = 1'b1;
    repeat (4) @(negedge ref_clk);
    check(smode, 1'b0, "held mode select");
    frame(1'b0, own, -1, 1);
    frame(1'b0, DISC_CODE_DEF, -1, 1);
    chk_st("disconnect");
    frame(1'b0, own ^ 10'h200, -1, 1);
    chk_st("mismatch");
    frame(1'b0, SYNC_CODE_DEF, -1, 1);
    chk_st("sync outside pause");
    steps(8'h0a, 4);
    frame(1'b0, SYNC_CODE_DEF, -1, 2);
    chk_st("sync in pause");
    @(negedge ref_clk);
    trst_n = 1'b0;
    exp_st = 0;
    steps(8'h3f, 6);
    chk_st("test reset");
    @(negedge ref_clk);
    trst_n = 1'b1;
    frame(1'b1, own, -1, 1);
    frame(1'b1, RST_CODE_DEF, -1, 1);
    chk_st("reset code");
    @(negedge ref_clk);
    force_n = 1'b0;
    #1 check(link_n, 1'b0, "forced indicator");
    check(sdo, tdi, "forced data");
    frame(1'b1, own, -1, 1);
    check(status === LS_RESET, 1'b1, "forced ignores frame");
    @(negedge ref_clk);
    trst_n = 1'b0;
    steps(8'h1f, 5);
    tms = 1'b0;
    #1 check(smode, 1'b1, "forced reset mode select");
    check(pdo, sdi, "forced reset data");
    check(secondary_test_reset_n_n, trst_n, "reset pass");
    @(negedge ref_clk);
    trst_n = 1'b1;
    #1 check(smode, tms, "forced link resumes");
    check(link_n, 1'b0, "forced link indicator");
    @(negedge ref_clk);
    force_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk_st("force release");
    end_of_test();
  end
endmodule
`default_nettype wire
